// file: rtl/clock_source_fail_monitor.sv
// clock source selection, switching and clock fail monitor with apb regs
// assumes oscillator ready, lock and tick inputs synchronous to REF_CLK
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module clock_source_fail_monitor (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] CONFIG_WORD,
  input wire logic SLEEP,
  input wire logic SYSCLK_ACTIVE,
  input wire logic SLOW_RC_TICK,
  input wire logic POSC_READY,
  input wire logic SOSC_READY,
  input wire logic PLL_LOCK,
  input wire logic POWERUP_DONE,
  output clk_mon_pkg::src_t SYS_SRC,
  output clk_mon_pkg::osc_en_t OSC_EN,
  output logic CLK_FAIL_TRAP
);

  typedef struct packed {
    clk_mon_pkg::state_t state;
    clk_mon_pkg::ctl_t ctl;
    clk_mon_pkg::cfg_t cfg;
    logic powerup;
    logic mon_arm;
    logic [15:0] mon_cnt;
    logic trap;
    clk_mon_pkg::osc_en_t en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } st_t;

  st_t r;
  st_t n;
  logic sw_en;
  logic mon_en;
  logic busy;
  logic acc;
  logic fin;
  logic tgt_ready;
  logic cur_ready;
  clk_mon_pkg::ctl_t wctl;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_frc(input clk_mon_pkg::src_t c);
    is_frc = (c == clk_mon_pkg::SRC_FRC) ||
             (c == clk_mon_pkg::SRC_FRC_PLL) ||
             (c == clk_mon_pkg::SRC_FRC_DIV16) ||
             (c == clk_mon_pkg::SRC_FRC_DIVN);
  endfunction

  function automatic logic is_posc(input clk_mon_pkg::src_t c);
    is_posc = (c == clk_mon_pkg::SRC_POSC) ||
              (c == clk_mon_pkg::SRC_POSC_PLL);
  endfunction

  function automatic logic is_pll(input clk_mon_pkg::src_t c);
    is_pll = (c == clk_mon_pkg::SRC_FRC_PLL) ||
             (c == clk_mon_pkg::SRC_POSC_PLL);
  endfunction

  function automatic logic is_xtal(input clk_mon_pkg::src_t c);
    is_xtal = is_posc(c) || (c == clk_mon_pkg::SRC_SOSC);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.trap = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.ctl.lock = PLL_LOCK;
    wctl = clk_mon_pkg::ctl_t'(PWDATA[15:0]);
    sw_en = ~r.cfg.switch_monitor_config[1];
    mon_en = (r.cfg.switch_monitor_config == clk_mon_pkg::SMC_BOTH);
    busy = (r.state == clk_mon_pkg::ST_SWITCH);
    acc = PSEL && PENABLE && !r.pready;
    fin = PSEL && PENABLE && r.pready;
    // slow rc needs no start-up wait
    cur_ready = is_posc(r.ctl.active_source_code) ? POSC_READY :
                (r.ctl.active_source_code == clk_mon_pkg::SRC_SOSC) ?
                SOSC_READY : 1'b1;
    tgt_ready = is_posc(r.ctl.requested_source_code) ? POSC_READY :
                (r.ctl.requested_source_code == clk_mon_pkg::SRC_SOSC) ?
                SOSC_READY : 1'b1;
    if (is_pll(r.ctl.requested_source_code) && r.cfg.wait_lock_enable &&
        !PLL_LOCK) begin
      tgt_ready = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // apb: one wait state, read data captured with pready
    if (acc) begin
      n.pready = 1'b1;
      if (PADDR == clk_mon_pkg::OFF_CONTROL) begin
        n.prdata = {16'h0000, r.ctl};
      end else if (PADDR == clk_mon_pkg::OFF_CONFIG) begin
        n.prdata = {16'h0000, r.cfg};
      end else if (PADDR == clk_mon_pkg::OFF_STATUS) begin
        n.prdata = {20'h00000, r.state, r.powerup, r.mon_arm,
                    3'h0, r.en};
      end else begin
        n.prdata = 32'h00000000;
        n.pslverr = 1'b1;
      end
    end
    if (fin && PWRITE && (PADDR == clk_mon_pkg::OFF_CONTROL) &&
        !busy) begin
      n.ctl.crystal2_keep_on = wctl.crystal2_keep_on;
      n.ctl.requested_source_code = wctl.requested_source_code;
      n.ctl.switch_request = wctl.switch_request && sw_en;
      if (!wctl.clock_fail_flag) begin
        n.ctl.clock_fail_flag = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////
    // switch sequencer
    if (POWERUP_DONE) begin
      n.powerup = 1'b0;
    end
    case (r.state)
      clk_mon_pkg::ST_BOOT: begin
        n.cfg = clk_mon_pkg::cfg_t'(CONFIG_WORD & clk_mon_pkg::CFG_MASK);
        n.powerup = (CONFIG_WORD[6:4] != 3'h0);
        n.ctl.requested_source_code = n.cfg.reset_source_select;
        if (n.cfg.two_speed && is_xtal(n.cfg.reset_source_select)) begin
          n.ctl.active_source_code = clk_mon_pkg::SRC_FRC;
          n.ctl.switch_request = 1'b1;
          n.state = clk_mon_pkg::ST_SWITCH;
        end else begin
          n.ctl.active_source_code = n.cfg.reset_source_select;
          n.state = clk_mon_pkg::ST_RUN;
        end
      end
      clk_mon_pkg::ST_RUN: begin
        if (r.ctl.switch_request) begin
          if (r.ctl.requested_source_code ==
              r.ctl.active_source_code) begin
            n.ctl.switch_request = 1'b0;
          end else begin
            n.state = clk_mon_pkg::ST_SWITCH;
          end
        end
      end
      clk_mon_pkg::ST_SWITCH: begin
        if (SLEEP || !r.ctl.switch_request) begin
          n.ctl.switch_request = 1'b0;
          n.state = clk_mon_pkg::ST_RUN;
        end else if (tgt_ready) begin
          n.ctl.active_source_code = r.ctl.requested_source_code;
          n.ctl.switch_request = 1'b0;
          n.mon_arm = 1'b0;
          n.mon_cnt = 16'h0000;
          n.state = clk_mon_pkg::ST_RUN;
        end
      end
      default: begin
        n.state = clk_mon_pkg::ST_BOOT;
      end
    endcase

    //////////////////////////////////////////////////////////////////////
    // fail monitor, timed on slow rc ticks
    if (!mon_en || SLEEP || r.state == clk_mon_pkg::ST_BOOT) begin
      n.mon_arm = 1'b0;
      n.mon_cnt = 16'h0000;
    end else if (!r.mon_arm) begin
      if (!cur_ready) begin
        n.mon_cnt = 16'h0000;
      end else if (!is_xtal(r.ctl.active_source_code) ||
                   r.mon_cnt == clk_mon_pkg::MONITOR_START_DELAY) begin
        n.mon_arm = 1'b1;
        n.mon_cnt = 16'h0000;
      end else if (SLOW_RC_TICK) begin
        n.mon_cnt = r.mon_cnt + 16'h0001;
      end
    end else if (SYSCLK_ACTIVE) begin
      n.mon_cnt = 16'h0000;
    end else if (SLOW_RC_TICK) begin
      n.mon_cnt = r.mon_cnt + 16'h0001;
      if (n.mon_cnt == clk_mon_pkg::MONITOR_WINDOW) begin
        n.trap = 1'b1;
        n.ctl.active_source_code = clk_mon_pkg::SRC_FRC;
        n.ctl.clock_fail_flag = 1'b1;
        n.ctl.switch_request = 1'b0;
        n.state = clk_mon_pkg::ST_RUN;
        n.mon_arm = 1'b0;
        n.mon_cnt = 16'h0000;
      end
    end

    //////////////////////////////////////////////////////////////////////
    // oscillator enables; old and new both on during a switch
    n.en.fast_internal_rc = !SLEEP && (is_frc(r.ctl.active_source_code)
        || (busy && is_frc(r.ctl.requested_source_code)));
    n.en.posc = !SLEEP && (is_posc(r.ctl.active_source_code) ||
        (busy && is_posc(r.ctl.requested_source_code)));
    n.en.pll = !SLEEP && (is_pll(r.ctl.active_source_code) ||
        (busy && is_pll(r.ctl.requested_source_code)));
    n.en.crystal2 = r.ctl.crystal2_keep_on ||
        (!SLEEP && (r.ctl.active_source_code == clk_mon_pkg::SRC_SOSC ||
        (busy && r.ctl.requested_source_code ==
        clk_mon_pkg::SRC_SOSC)));
    if (SLEEP) begin
      n.en.slow_rc_osc = r.cfg.watchdog_en;
    end else begin
      n.en.slow_rc_osc = r.powerup || mon_en ||
          r.cfg.watchdog_en ||
          r.ctl.active_source_code == clk_mon_pkg::SRC_SLOW_RC ||
          (busy && r.ctl.requested_source_code ==
          clk_mon_pkg::SRC_SLOW_RC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign SYS_SRC = r.ctl.active_source_code;
  assign OSC_EN = r.en;
  assign CLK_FAIL_TRAP = r.trap;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_switch_end;
    r.state == clk_mon_pkg::ST_SWITCH && !SLEEP && r.ctl.switch_request
      && tgt_ready && !n.trap;
  endsequence

  a_trap_cause: assert property (
    r.trap |-> $past(r.mon_arm) && $past(mon_en))
    else $error("trap without armed monitor");
  a_trap_frc: assert property (
    r.trap |-> r.ctl.active_source_code == clk_mon_pkg::SRC_FRC)
    else $error("fallback not on fast rc");
  a_trap_flag: assert property (
    r.trap |-> r.ctl.clock_fail_flag ##1 r.ctl.clock_fail_flag)
    else $error("fail flag not set");
  a_trap_cancel: assert property (
    r.trap |-> !r.ctl.switch_request && r.state == clk_mon_pkg::ST_RUN)
    else $error("pending switch not cancelled");
  a_keep_crystal2: assert property (
    r.ctl.crystal2_keep_on |=> OSC_EN.crystal2)
    else $error("crystal2 dropped with keep-on");
  a_sleep_stop: assert property (
    SLEEP |=> !OSC_EN.fast_internal_rc && !OSC_EN.posc && !OSC_EN.pll)
    else $error("oscillator running in sleep");
  a_sleep_slow_rc: assert property (
    SLEEP |=> OSC_EN.slow_rc_osc == $past(r.cfg.watchdog_en))
    else $error("slow rc wrong in sleep");
  a_same_source: assert property (
    r.state == clk_mon_pkg::ST_RUN && r.ctl.switch_request &&
    r.ctl.requested_source_code == r.ctl.active_source_code
    |=> !r.ctl.switch_request && r.state == clk_mon_pkg::ST_RUN)
    else $error("redundant switch not dropped");
  a_switch_done: assert property (
    s_switch_end |=> !r.ctl.switch_request &&
    r.ctl.active_source_code == $past(r.ctl.requested_source_code))
    else $error("switch completion wrong");
  a_lock_wait: assert property (
    r.state == clk_mon_pkg::ST_SWITCH && !n.trap && r.cfg.wait_lock_enable
    && is_pll(r.ctl.requested_source_code) && !PLL_LOCK
    |=> r.ctl.active_source_code == $past(r.ctl.active_source_code))
    else $error("pll switch before lock");
  a_busy_lockout: assert property (
    busy && fin && PWRITE && PADDR == clk_mon_pkg::OFF_CONTROL
    |=> r.ctl.crystal2_keep_on == $past(r.ctl.crystal2_keep_on))
    else $error("control written during switch");
  a_make_break: assert property (
    busy && !SLEEP && is_frc(r.ctl.active_source_code)
    |=> OSC_EN.fast_internal_rc)
    else $error("old source stopped during switch");

endmodule

// file: rtl/clk_mon_pkg.sv
// constants and types shared by the clock source and fail monitor block
// assumes a 32-bit apb master and 16-bit configuration words
package clk_mon_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  ////////////////////////////////////////////////////////////////////////
  // clock source codes
  typedef enum logic [2:0] {
    SRC_FRC = 3'b000,
    SRC_FRC_PLL = 3'b001,
    SRC_POSC = 3'b010,
    SRC_POSC_PLL = 3'b011,
    SRC_SOSC = 3'b100,
    SRC_SLOW_RC = 3'b101,
    SRC_FRC_DIV16 = 3'b110,
    SRC_FRC_DIVN = 3'b111
  } src_t;

  // switch_monitor_config encodings
  localparam logic [1:0] SMC_BOTH = 2'h0;
  localparam logic [1:0] SMC_SWITCH_ONLY = 2'h1;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01,
    ST_SWITCH = 2'b10
  } state_t;

  ////////////////////////////////////////////////////////////////////////
  // osc_control layout
  typedef struct packed {
    logic rsv15;
    src_t active_source_code;
    logic rsv11;
    src_t requested_source_code;
    logic [1:0] rsv7;
    logic lock;
    logic rsv4;
    logic clock_fail_flag;
    logic rsv2;
    logic crystal2_keep_on;
    logic switch_request;
  } ctl_t;

  // configuration word layout, caught at reset release
  typedef struct packed {
    logic rsv15;
    logic two_speed;
    logic watchdog_en;
    logic wait_lock_enable;
    logic [1:0] rsv10;
    logic [1:0] switch_monitor_config;
    logic rsv7;
    logic [2:0] powerup_delay_select;
    logic rsv3;
    src_t reset_source_select;
  } cfg_t;

  localparam logic [15:0] CFG_MASK = 16'h7377;

  typedef struct packed {
    logic pll;
    logic posc;
    logic fast_internal_rc;
    logic slow_rc_osc;
    logic crystal2;
  } osc_en_t;

  ////////////////////////////////////////////////////////////////////////
  // monitor timing, in slow_rc_osc ticks
  localparam logic [15:0] MONITOR_START_DELAY = 16'h0010;
  localparam logic [15:0] MONITOR_WINDOW = 16'h0004;

endpackage

// file: testbench/osc_partner.sv
// behavioural model of the oscillators and clock activity around the block
// assumes OSC_EN from the block and bench controls on the same REF_CLK
`timescale 1ns/1ps

module osc_partner (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire clk_mon_pkg::osc_en_t OSC_EN,
  input wire logic CLK_DEAD,
  input wire logic [7:0] START_CYC,
  output logic POSC_READY,
  output logic SOSC_READY,
  output logic PLL_LOCK,
  output logic SLOW_RC_TICK,
  output logic SYSCLK_ACTIVE
);
  logic [7:0] posc_cnt;
  logic [7:0] sosc_cnt;
  logic [7:0] pll_cnt;
  logic [1:0] div;

  function automatic logic [7:0] up(input logic en, input logic [7:0] c);
    return en ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // ready drops as soon as the source is disabled
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      posc_cnt <= 8'h00;
      sosc_cnt <= 8'h00;
      pll_cnt <= 8'h00;
      div <= 2'h0;
      POSC_READY <= 1'h0;
      SOSC_READY <= 1'h0;
      PLL_LOCK <= 1'h0;
      SLOW_RC_TICK <= 1'h0;
      SYSCLK_ACTIVE <= 1'h0;
    end else begin
      posc_cnt <= up(OSC_EN.posc, posc_cnt);
      sosc_cnt <= up(OSC_EN.crystal2, sosc_cnt);
      pll_cnt <= up(OSC_EN.pll, pll_cnt);
      POSC_READY <= OSC_EN.posc && (POSC_READY || posc_cnt >= START_CYC);
      SOSC_READY <= OSC_EN.crystal2 && (SOSC_READY || sosc_cnt >= START_CYC);
      PLL_LOCK <= OSC_EN.pll && (PLL_LOCK || pll_cnt >= START_CYC);
      div <= OSC_EN.slow_rc_osc ? div + 2'h1 : 2'h0;
      SLOW_RC_TICK <= OSC_EN.slow_rc_osc && div == 2'h3;
      SYSCLK_ACTIVE <= !CLK_DEAD;
    end
  end
endmodule

// file: testbench/testbench.sv
// self-checking bench: apb register access plus oscillator scenarios
// assumes osc_partner drives ready, lock, tick and clock activity inputs
`timescale 1ns/1ps

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) begin n = 0; while ((c) !== 1'h1 && n < 600) begin \
  @(posedge REF_CLK); n++; end if (n >= 600) begin fail_count++; \
  results(); end end

module testbench;
  logic REF_CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, e, SLEEP = 0, POWERUP_DONE = 0, CLK_FAIL_TRAP;
  logic [15:0] CONFIG_WORD = 16'h0;
  logic SYSCLK_ACTIVE, SLOW_RC_TICK, POSC_READY, SOSC_READY, PLL_LOCK;
  logic clk_dead = 0;
  logic [7:0] start_cyc = 8'h14;
  clk_mon_pkg::src_t SYS_SRC;
  clk_mon_pkg::osc_en_t OSC_EN;
  int fail_count = 0, checks_done = 0, n = 0, traps = 0, t0 = 0;

  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (CLK_FAIL_TRAP === 1'h1) traps++;

  clock_source_fail_monitor u_clock_source_fail_monitor (
    .REF_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .CONFIG_WORD, .SLEEP, .SYSCLK_ACTIVE, .SLOW_RC_TICK,
    .POSC_READY, .SOSC_READY, .PLL_LOCK, .POWERUP_DONE, .SYS_SRC, .OSC_EN,
    .CLK_FAIL_TRAP);

  osc_partner u_osc_partner (
    .REF_CLK, .RST_B, .OSC_EN, .CLK_DEAD(clk_dead), .START_CYC(start_cyc),
    .POSC_READY, .SOSC_READY, .PLL_LOCK, .SLOW_RC_TICK, .SYSCLK_ACTIVE);

  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    @(posedge REF_CLK);
    while (PREADY !== 1'h1 && k < 20) begin
      @(posedge REF_CLK);
      k++;
    end
    q = PRDATA;
    e = PSLVERR;
    if (k >= 20) begin
      fail_count++;
      results();
    end
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge REF_CLK);
  endtask

  task automatic rst(input logic [15:0] w);
    RST_B <= 1'h0;
    CONFIG_WORD <= w;
    POWERUP_DONE <= 1'h0;
    SLEEP <= 1'h0;
    clk_dead <= 1'h0;
    repeat (5) @(posedge REF_CLK);
    RST_B <= 1'h1;
    @(posedge REF_CLK);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    @(posedge REF_CLK);
    rst(16'h1010);
    POWERUP_DONE <= 1'h1;
    apb(1'h0, clk_mon_pkg::OFF_CONFIG, 32'h0);
    `CHK(q, 32'h0000_1010)
    `CHK(OSC_EN.slow_rc_osc, 1'h1)
    apb(1'h0, 8'h0C, 32'h0);
    `CHK(e, 1'h1)
    `CHK(q, 32'h0)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0401);
    `WAITC(SYS_SRC === clk_mon_pkg::SRC_SOSC)
    `CHK(SOSC_READY, 1'h1)
    `CHK(OSC_EN.crystal2, 1'h1)
    apb(1'h0, clk_mon_pkg::OFF_CONTROL, 32'h0);
    `CHK(q[14:12], 3'h4)
    `CHK(q[0], 1'h0)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0401);
    repeat (3) @(posedge REF_CLK);
    apb(1'h0, clk_mon_pkg::OFF_CONTROL, 32'h0);
    `CHK(q[0], 1'h0)
    `CHK(SYS_SRC, clk_mon_pkg::SRC_SOSC)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0301);
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0302);
    `CHK(SYS_SRC, clk_mon_pkg::SRC_SOSC)
    `WAITC(SYS_SRC === clk_mon_pkg::SRC_POSC_PLL)
    `CHK(PLL_LOCK, 1'h1)
    `CHK(OSC_EN.posc, 1'h1)
    apb(1'h0, clk_mon_pkg::OFF_CONTROL, 32'h0);
    `CHK(q[1], 1'h0)
    `CHK(OSC_EN.crystal2, 1'h0)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0302);
    repeat (2) @(posedge REF_CLK);
    `CHK(OSC_EN.crystal2, 1'h1)
    SLEEP <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    `CHK({OSC_EN.pll, OSC_EN.posc, OSC_EN.fast_internal_rc}, 3'h0)
    `CHK({OSC_EN.slow_rc_osc, OSC_EN.crystal2}, 2'h1)
    SLEEP <= 1'h0;
    `WAITC(POSC_READY === 1'h1)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0300);
    start_cyc <= 8'hFF;
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0401);
    clk_dead <= 1'h1;
    `WAITC(CLK_FAIL_TRAP === 1'h1)
    `CHK(SYS_SRC, clk_mon_pkg::SRC_FRC)
    `CHK(OSC_EN.slow_rc_osc, 1'h1)
    clk_dead <= 1'h0;
    apb(1'h0, clk_mon_pkg::OFF_CONTROL, 32'h0);
    `CHK(q[14:12], 3'h0)
    `CHK(q[3], 1'h1)
    `CHK(q[0], 1'h0)
    start_cyc <= 8'h28;
    rst(16'hE112);
    apb(1'h0, clk_mon_pkg::OFF_CONFIG, 32'h0);
    `CHK(q, 32'h0000_6112)
    `CHK(SYS_SRC, clk_mon_pkg::SRC_FRC)
    `WAITC(SYS_SRC === clk_mon_pkg::SRC_POSC)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0301);
    repeat (3) @(posedge REF_CLK);
    `CHK(SYS_SRC, clk_mon_pkg::SRC_POSC_PLL)
    `CHK(PLL_LOCK, 1'h0)
    POWERUP_DONE <= 1'h1;
    t0 = traps;
    clk_dead <= 1'h1;
    repeat (150) @(posedge REF_CLK);
    `CHK(traps, t0)
    `CHK(OSC_EN.slow_rc_osc, 1'h1)
    SLEEP <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    `CHK(OSC_EN.slow_rc_osc, 1'h1)
    rst(16'h0210);
    repeat (2) @(posedge REF_CLK);
    `CHK(OSC_EN.slow_rc_osc, 1'h1)
    apb(1'h1, clk_mon_pkg::OFF_CONTROL, 32'h0000_0401);
    repeat (60) @(posedge REF_CLK);
    `CHK(SYS_SRC, clk_mon_pkg::SRC_FRC)
    POWERUP_DONE <= 1'h1;
    repeat (3) @(posedge REF_CLK);
    `CHK(OSC_EN.slow_rc_osc, 1'h0)
    results();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    results();
  end
endmodule
